// file: common/mbw_pkg.sv
// constants, encodings and timeout tables of the boot and runtime watchdog
package mbw_pkg;

	// ------------------------------------------------------------------
	// clock and timebase
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 200000000;        // system clock rate
	localparam int unsigned TICK_MS     = 1;                // timebase period in ms
	localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS; // cycles per tick
	localparam int unsigned TICK_W      = 18;               // divider width
	localparam int unsigned MS_W        = 21;               // holds 30 min in ms

	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0]  ADR_CTRL    = 8'h00;            // configuration
	localparam logic [7:0]  ADR_TMO     = 8'h04;            // stage timeout selects
	localparam logic [7:0]  ADR_KICK    = 8'h08;            // trigger and arm strobes
	localparam logic [7:0]  ADR_POST    = 8'h0C;            // self-test phase flags
	localparam logic [7:0]  ADR_STS     = 8'h10;            // sticky events, write 1 clears
	localparam logic [7:0]  ADR_MASK    = 8'h14;            // interrupt mask
	localparam logic [7:0]  ADR_STATE   = 8'h18;            // runtime state and time left

	// ------------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned CTRL_POST_LSB = 0;              // [2:0] boot timeout select
	localparam int unsigned CTRL_STOPUI   = 3;              // halt during user interaction
	localparam int unsigned CTRL_MODE_LSB = 4;              // [5:4] runtime mode
	localparam int unsigned CTRL_DLY_LSB  = 6;              // [8:6] start delay select
	localparam int unsigned CTRL_EV1_LSB  = 9;              // [10:9] stage 1 action
	localparam int unsigned CTRL_EV2_LSB  = 11;             // [12:11] stage 2 action
	localparam int unsigned CTRL_EV3_LSB  = 13;             // [14:13] stage 3 action
	localparam int unsigned CTRL_RESTART  = 15;             // os event asks for restart
	localparam logic [15:0] CTRL_RST      = 16'h0208;       // stop-ui set, stage 1 = os event
	localparam logic [11:0] TMO_RST       = 12'h000;        // all stages 1 s
	localparam int unsigned KICK_TRIG     = 0;              // software trigger
	localparam int unsigned KICK_ARM      = 1;              // start runtime watchdog
	localparam int unsigned POST_RUN      = 0;              // self-test running
	localparam int unsigned POST_UIWAIT   = 1;              // popup or password shown
	localparam int unsigned STS_W         = 4;              // post, stage 1..3

	// ------------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] { MODE_DIS = 2'h0, MODE_ONCE = 2'h1, MODE_SINGLE = 2'h2,
		MODE_REPEAT = 2'h3 } mbw_mode_e;
	// no interrupt-style action exists, only these four
	typedef enum logic [1:0] { ACT_NONE = 2'h0, ACT_OS = 2'h1, ACT_RST = 2'h2,
		ACT_PWR = 2'h3 } mbw_act_e;
	typedef enum logic [2:0] { RT_OFF = 3'b000, RT_DELAY = 3'b001, RT_STG1 = 3'b010,
		RT_STG2 = 3'b011, RT_STG3 = 3'b100 } mbw_rt_e;

	// ------------------------------------------------------------------
	// timeout tables in ms
	// ------------------------------------------------------------------
	function automatic logic [MS_W-1:0] post_ms(input logic [2:0] s);
		case (s)
			3'h1:    post_ms = 21'd30000;
			3'h2:    post_ms = 21'd60000;
			3'h3:    post_ms = 21'd120000;
			3'h4:    post_ms = 21'd300000;
			3'h5:    post_ms = 21'd600000;
			default: post_ms = 21'd1800000;
		endcase
	endfunction

	function automatic logic [MS_W-1:0] delay_ms(input logic [2:0] s);
		case (s)
			3'h1:    delay_ms = 21'd10000;
			3'h2:    delay_ms = 21'd30000;
			3'h3:    delay_ms = 21'd60000;
			3'h4:    delay_ms = 21'd120000;
			3'h5:    delay_ms = 21'd300000;
			3'h6:    delay_ms = 21'd600000;
			default: delay_ms = 21'd1800000;
		endcase
	endfunction

	function automatic logic [MS_W-1:0] stage_ms(input logic [3:0] s);
		case (s)
			4'h0:    stage_ms = 21'd1000;
			4'h1:    stage_ms = 21'd2000;
			4'h2:    stage_ms = 21'd5000;
			4'h3:    stage_ms = 21'd10000;
			4'h4:    stage_ms = 21'd30000;
			4'h5:    stage_ms = 21'd60000;
			4'h6:    stage_ms = 21'd120000;
			4'h7:    stage_ms = 21'd300000;
			4'h8:    stage_ms = 21'd600000;
			default: stage_ms = 21'd1800000;
		endcase
	endfunction

endpackage

// file: common/mbw_cnt_if.sv
// control and status wires between the watchdog core and a countdown timer
`timescale 1ns/1ps
interface mbw_cnt_if;
	logic                      load;    // reload remaining time
	logic                      run;     // count on ticks
	logic [mbw_pkg::MS_W-1:0]  load_ms; // value to reload
	logic                      expired; // one-cycle pulse at zero
	logic [mbw_pkg::MS_W-1:0]  remain;  // ms left

	modport ctl (output load, output run, output load_ms, input expired, input remain);
	modport cnt (input load, input run, input load_ms, output expired, output remain);
endinterface

// file: hw/mbw_cnt.sv
// millisecond countdown timer with reload, pause and expiry pulse
`timescale 1ns/1ps
module mbw_cnt (
	input  wire logic  clk,  // system clock
	input  wire logic  rst,  // synchronous reset, active high
	input  wire logic  tick, // one-cycle ms enable
	mbw_cnt_if.cnt     ci    // timer control
);

	logic [mbw_pkg::MS_W-1:0] remain_ff;  // ms left
	logic                     expired_ff; // expiry pulse

	// ------------------------------------------------------------------
	// countdown
	// ------------------------------------------------------------------
	// reload wins over counting; pausing just stops the decrement
	always_ff @(posedge clk)
	begin
		if (rst)
			remain_ff <= '0;
		else if (ci.load)
			remain_ff <= ci.load_ms;
		else if (ci.run && tick && remain_ff != '0)
			remain_ff <= remain_ff - 1'b1;
	end

	// pulse in the cycle after the last ms ran out
	always_ff @(posedge clk)
	begin
		if (rst)
			expired_ff <= 1'b0;
		else
			expired_ff <= !ci.load && ci.run && tick && remain_ff == 21'd1;
	end

	assign ci.remain  = remain_ff;
	assign ci.expired = expired_ff;

endmodule

// file: hw/mbw_wdt.sv
// boot-time supervisor and three-stage runtime watchdog with wishbone registers
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module mbw_wdt #(
	parameter int unsigned TICK_CYC = mbw_pkg::TICK_CYC // cycles per ms tick
) (
	input  wire logic        clk,          // 200 MHz system clock
	input  wire logic        rst,          // synchronous reset, active high
	input  wire logic        wb_cyc_i,     // wishbone cycle
	input  wire logic        wb_stb_i,     // wishbone strobe
	input  wire logic        wb_we_i,      // wishbone write enable
	input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
	input  wire logic [3:0]  wb_sel_i,     // wishbone byte lanes
	input  wire logic [31:0] wb_dat_i,     // wishbone write data
	output logic      [31:0] wb_dat_o,     // wishbone read data
	output logic             wb_ack_o,     // wishbone acknowledge
	output logic             irq,          // level interrupt
	output logic             sys_rst_req,  // system reset request pulse
	output logic             pwr_btn_evt,  // power button event pulse
	output logic             os_evt,       // os notification event pulse
	output logic             os_evt_restart // os event kind: 1 restart, 0 shutdown
);
	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	localparam int unsigned   TICK_W_L = mbw_pkg::TICK_W; // divider width
	logic [TICK_W_L-1:0]      tick_cnt_ff;    // ms divider
	logic                     tick_ff;        // ms enable pulse
	logic                     ack_ff;         // bus acknowledge
	logic [31:0]              rdat_ff;        // bus read data
	logic [15:0]              ctrl_ff;        // configuration
	logic [11:0]              tmo_ff;         // stage timeout selects
	logic [1:0]               post_ff;        // self-test flags
	logic [mbw_pkg::STS_W-1:0] sts_ff;        // sticky events
	logic [mbw_pkg::STS_W-1:0] mask_ff;       // interrupt mask
	logic                     irq_ff;         // interrupt level
	logic                     srst_ff;        // reset request
	logic                     pwr_ff;         // power button request
	logic                     os_ff;          // os event request
	mbw_pkg::mbw_rt_e         rt_ff;          // runtime state
	mbw_pkg::mbw_rt_e         nxt_rt;         // next runtime state
	logic                     rt_load;        // reload runtime timer
	logic [mbw_pkg::MS_W-1:0] rt_load_ms;     // runtime reload value
	mbw_pkg::mbw_act_e        fire_act;       // action fired this cycle
	logic [mbw_pkg::STS_W-1:0] evt_set;       // events this cycle
	logic [31:0]              wmask;          // byte lane mask
	logic                     req;            // new bus request
	logic                     wr_go;          // write takes effect
	logic                     kick_trig;      // trigger strobe
	logic                     kick_arm;       // arm strobe
	logic                     post_hold;      // boot timer halted
	mbw_pkg::mbw_mode_e       mode;           // runtime mode field
	mbw_pkg::mbw_act_e        act1;           // stage 1 action
	mbw_pkg::mbw_act_e        act2;           // stage 2 action
	mbw_pkg::mbw_act_e        act3;           // stage 3 action
	mbw_cnt_if                rt_if ();       // runtime timer wires
	mbw_cnt_if                post_if ();     // boot timer wires
	// ------------------------------------------------------------------
	// field views
	// ------------------------------------------------------------------
	assign mode = mbw_pkg::mbw_mode_e'(ctrl_ff[mbw_pkg::CTRL_MODE_LSB +: 2]);
	// stage 1 cannot be disabled: a none code is taken as os event
	assign act1 = (ctrl_ff[mbw_pkg::CTRL_EV1_LSB +: 2] == 2'h0) ? mbw_pkg::ACT_OS :
		mbw_pkg::mbw_act_e'(ctrl_ff[mbw_pkg::CTRL_EV1_LSB +: 2]);
	assign act2 = mbw_pkg::mbw_act_e'(ctrl_ff[mbw_pkg::CTRL_EV2_LSB +: 2]);
	assign act3 = mbw_pkg::mbw_act_e'(ctrl_ff[mbw_pkg::CTRL_EV3_LSB +: 2]);
	// ------------------------------------------------------------------
	// ms timebase
	// ------------------------------------------------------------------
	// free-running divider, wraps once per ms
	always_ff @(posedge clk)
	begin
		if (rst || tick_cnt_ff == TICK_W_L'(TICK_CYC - 1))
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
	end
	// one enable pulse as the divider wraps
	always_ff @(posedge clk)
	begin
		if (rst)
			tick_ff <= 1'b0;
		else
			tick_ff <= tick_cnt_ff == TICK_W_L'(TICK_CYC - 1);
	end
	// ------------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------------
	// one byte-lane mask bit per data bit
	for (genvar b = 0; b < 4; b++)
	begin : g_lane
		assign wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
	end
	assign req       = wb_cyc_i && wb_stb_i && !ack_ff;
	// writes land on the edge where the master sees ack
	assign wr_go     = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
	assign kick_trig = wr_go && wb_adr_i == mbw_pkg::ADR_KICK &&
		wmask[mbw_pkg::KICK_TRIG] && wb_dat_i[mbw_pkg::KICK_TRIG];
	assign kick_arm  = wr_go && wb_adr_i == mbw_pkg::ADR_KICK &&
		wmask[mbw_pkg::KICK_ARM] && wb_dat_i[mbw_pkg::KICK_ARM];
	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk)
	begin
		if (rst)
			ack_ff <= 1'b0;
		else
			ack_ff <= req;
	end
	// read mux sampled with the request; unmapped reads return zero
	always_ff @(posedge clk)
	begin
		if (rst)
			rdat_ff <= '0;
		else if (req)
		begin
			if (wb_adr_i == mbw_pkg::ADR_CTRL)
				rdat_ff <= {16'h0000, ctrl_ff};
			else if (wb_adr_i == mbw_pkg::ADR_TMO)
				rdat_ff <= {20'h00000, tmo_ff};
			else if (wb_adr_i == mbw_pkg::ADR_POST)
				rdat_ff <= {30'h00000000, post_ff};
			else if (wb_adr_i == mbw_pkg::ADR_STS)
				rdat_ff <= {28'h0000000, sts_ff};
			else if (wb_adr_i == mbw_pkg::ADR_MASK)
				rdat_ff <= {28'h0000000, mask_ff};
			else if (wb_adr_i == mbw_pkg::ADR_STATE)
				rdat_ff <= {3'h0, rt_if.remain, 5'h00, rt_ff};
			else
				rdat_ff <= '0;
		end
	end
	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	// boot timeout, runtime mode, delay, actions and os event kind
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl_ff <= mbw_pkg::CTRL_RST;
		else if (wr_go && wb_adr_i == mbw_pkg::ADR_CTRL)
			ctrl_ff <= (ctrl_ff & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
	end
	// three independent stage timeout selects
	always_ff @(posedge clk)
	begin
		if (rst)
			tmo_ff <= mbw_pkg::TMO_RST;
		else if (wr_go && wb_adr_i == mbw_pkg::ADR_TMO)
			tmo_ff <= (tmo_ff & ~wmask[11:0]) | (wb_dat_i[11:0] & wmask[11:0]);
	end
	// self-test flags from firmware; running flag drops when boot timer fires
	always_ff @(posedge clk)
	begin
		if (rst)
			post_ff <= 2'h0;
		else if (post_if.expired)
			post_ff[mbw_pkg::POST_RUN] <= 1'b0;
		else if (wr_go && wb_adr_i == mbw_pkg::ADR_POST)
			post_ff <= (post_ff & ~wmask[1:0]) | (wb_dat_i[1:0] & wmask[1:0]);
	end
	// interrupt mask
	always_ff @(posedge clk)
	begin
		if (rst)
			mask_ff <= '0;
		else if (wr_go && wb_adr_i == mbw_pkg::ADR_MASK)
			mask_ff <= (mask_ff & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
	end
	// ------------------------------------------------------------------
	// boot-time watchdog
	// ------------------------------------------------------------------
	// halted while a boot prompt or password wait is flagged
	assign post_hold = ctrl_ff[mbw_pkg::CTRL_STOPUI] && post_ff[mbw_pkg::POST_UIWAIT];
	// reloads outside self-test, counts only during it and when enabled
	assign post_if.load    = !post_ff[mbw_pkg::POST_RUN];
	assign post_if.run     = post_ff[mbw_pkg::POST_RUN] &&
		ctrl_ff[mbw_pkg::CTRL_POST_LSB +: 3] != 3'h0 && !post_hold;
	assign post_if.load_ms = mbw_pkg::post_ms(ctrl_ff[mbw_pkg::CTRL_POST_LSB +: 3]);
	mbw_cnt u_post_cnt (
		.clk  (clk),
		.rst  (rst),
		.tick (tick_ff),
		.ci   (post_if)
	);
	// ------------------------------------------------------------------
	// runtime watchdog state machine
	// ------------------------------------------------------------------
	// trigger beats a same-cycle expiry; stages follow one after another
	always_comb
	begin
		nxt_rt     = rt_ff;
		rt_load    = 1'b0;
		rt_load_ms = mbw_pkg::stage_ms(tmo_ff[3:0]);
		fire_act   = mbw_pkg::ACT_NONE;
		evt_set    = '0;
		case (rt_ff)
			mbw_pkg::RT_OFF:
			begin
				// firmware arms just before the os boots
				if (kick_arm && mode != mbw_pkg::MODE_DIS)
				begin
					rt_load = 1'b1;
					if (ctrl_ff[mbw_pkg::CTRL_DLY_LSB +: 3] != 3'h0)
					begin
						nxt_rt     = mbw_pkg::RT_DELAY;
						rt_load_ms = mbw_pkg::delay_ms(ctrl_ff[mbw_pkg::CTRL_DLY_LSB +: 3]);
					end
					else
						nxt_rt = mbw_pkg::RT_STG1;
				end
			end
			mbw_pkg::RT_DELAY:
			begin
				// triggers are ignored until the delay has passed
				if (rt_if.expired)
				begin
					nxt_rt  = mbw_pkg::RT_STG1;
					rt_load = 1'b1;
				end
			end
			mbw_pkg::RT_STG1, mbw_pkg::RT_STG2, mbw_pkg::RT_STG3:
			begin
				if (kick_trig && mode == mbw_pkg::MODE_ONCE)
					nxt_rt = mbw_pkg::RT_OFF;
				else if (kick_trig)
				begin
					nxt_rt  = mbw_pkg::RT_STG1;
					rt_load = 1'b1;
				end
				else if (rt_if.expired && rt_ff == mbw_pkg::RT_STG1)
				begin
					fire_act   = act1;
					evt_set[1] = 1'b1;
					rt_load    = 1'b1;
					if (act2 != mbw_pkg::ACT_NONE)
					begin
						nxt_rt     = mbw_pkg::RT_STG2;
						rt_load_ms = mbw_pkg::stage_ms(tmo_ff[7:4]);
					end
					else if (mode == mbw_pkg::MODE_REPEAT)
						nxt_rt = mbw_pkg::RT_STG1;
					else
						nxt_rt = mbw_pkg::RT_OFF;
				end
				else if (rt_if.expired && rt_ff == mbw_pkg::RT_STG2)
				begin
					fire_act   = act2;
					evt_set[2] = 1'b1;
					rt_load    = 1'b1;
					rt_load_ms = mbw_pkg::stage_ms(tmo_ff[7:4]);
					if (act3 != mbw_pkg::ACT_NONE)
					begin
						nxt_rt     = mbw_pkg::RT_STG3;
						rt_load_ms = mbw_pkg::stage_ms(tmo_ff[11:8]);
					end
					else if (mode == mbw_pkg::MODE_REPEAT)
						nxt_rt = mbw_pkg::RT_STG2;
					else
						nxt_rt = mbw_pkg::RT_OFF;
				end
				else if (rt_if.expired)
				begin
					fire_act   = act3;
					evt_set[3] = 1'b1;
					rt_load    = 1'b1;
					rt_load_ms = mbw_pkg::stage_ms(tmo_ff[11:8]);
					if (mode == mbw_pkg::MODE_REPEAT)
						nxt_rt = mbw_pkg::RT_STG3;
					else
						nxt_rt = mbw_pkg::RT_OFF;
				end
			end
			default:
				nxt_rt = mbw_pkg::RT_OFF;
		endcase
		// clearing the mode stops a running watchdog at once
		if (mode == mbw_pkg::MODE_DIS)
			nxt_rt = mbw_pkg::RT_OFF;
		evt_set[0] = post_if.expired;
	end
	// runtime state register
	always_ff @(posedge clk)
	begin
		if (rst)
			rt_ff <= mbw_pkg::RT_OFF;
		else
			rt_ff <= nxt_rt;
	end
	assign rt_if.load    = rt_load;
	assign rt_if.load_ms = rt_load_ms;
	assign rt_if.run     = rt_ff != mbw_pkg::RT_OFF;
	mbw_cnt u_rt_cnt (
		.clk  (clk),
		.rst  (rst),
		.tick (tick_ff),
		.ci   (rt_if)
	);
	// ------------------------------------------------------------------
	// actions
	// ------------------------------------------------------------------
	// one-cycle requests; only os, reset and power button exist
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			srst_ff <= 1'b0;
			pwr_ff  <= 1'b0;
			os_ff   <= 1'b0;
		end
		else
		begin
			srst_ff <= post_if.expired || fire_act == mbw_pkg::ACT_RST;
			pwr_ff  <= fire_act == mbw_pkg::ACT_PWR;
			os_ff   <= fire_act == mbw_pkg::ACT_OS;
		end
	end
	// ------------------------------------------------------------------
	// status and interrupt
	// ------------------------------------------------------------------
	// set wins over a same-cycle write-one clear
	always_ff @(posedge clk)
	begin
		if (rst)
			sts_ff <= '0;
		else if (wr_go && wb_adr_i == mbw_pkg::ADR_STS)
			sts_ff <= (sts_ff & ~(wb_dat_i[3:0] & wmask[3:0])) | evt_set;
		else
			sts_ff <= sts_ff | evt_set;
	end
	// level interrupt while an unmasked event is pending
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(sts_ff & mask_ff);
	end
	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign wb_ack_o       = ack_ff;
	assign wb_dat_o       = rdat_ff;
	assign irq            = irq_ff;
	assign sys_rst_req    = srst_ff;
	assign pwr_btn_evt    = pwr_ff;
	assign os_evt         = os_ff;
	assign os_evt_restart = ctrl_ff[mbw_pkg::CTRL_RESTART];
endmodule

// file: tb/mbw_wdt_checker.sv
// concurrent checks on the watchdog top-level ports
`timescale 1ns/1ps
module mbw_wdt_checker #(
	parameter int unsigned TICK_CYC = 4 // cycles per ms tick
) (
	input wire logic        clk,           // clock
	input wire logic        rst,           // reset
	input wire logic        wb_cyc_i,      // cycle
	input wire logic        wb_stb_i,      // strobe
	input wire logic        wb_we_i,       // write
	input wire logic [7:0]  wb_adr_i,      // address
	input wire logic [3:0]  wb_sel_i,      // lanes
	input wire logic [31:0] wb_dat_i,      // write data
	input wire logic [31:0] wb_dat_o,      // read data
	input wire logic        wb_ack_o,      // ack
	input wire logic        irq,           // interrupt
	input wire logic        sys_rst_req,   // reset pulse
	input wire logic        pwr_btn_evt,   // power pulse
	input wire logic        os_evt,        // os pulse
	input wire logic        os_evt_restart // os event kind
);
	// ----
	// bus and action checks
	// ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire logic any_act = sys_rst_req | pwr_btn_evt | os_evt; // any action pulse
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1C |-> wb_dat_o == 0)
		else $error("unmapped read not zero");
	act_onehot_a: assert property ($onehot0({sys_rst_req, pwr_btn_evt, os_evt}))
		else $error("two actions at once");
	act_pulse_a: assert property (any_act |=> !any_act [*8])
		else $error("action pulse too long");
	restart_cfg_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1]
		|=> os_evt_restart == $past(wb_dat_i[15])) else $error("os event kind not updated");
	irq_mask_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h14 && wb_sel_i[0]
		&& wb_dat_i[3:0] == 4'h0 |=> ##1 !irq) else $error("irq with mask clear");
endmodule
bind mbw_wdt mbw_wdt_checker #(.TICK_CYC(TICK_CYC)) chk (.clk(clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq(irq), .sys_rst_req(sys_rst_req), .pwr_btn_evt(pwr_btn_evt), .os_evt(os_evt),
	.os_evt_restart(os_evt_restart));

// file: tb/mbw_os_model.sv
// host-side model turning os events into os notices
`timescale 1ns/1ps
module mbw_os_model (
	input  wire logic clk,            // clock
	input  wire logic rst,            // reset
	input  wire logic os_evt,         // os event pulse
	input  wire logic os_evt_restart, // restart, not shutdown
	output int        shut_cnt,       // over-temperature notices
	output int        fatal_cnt       // fatal error reports
);
	// firmware answers each event with the notice the os acts on
	always @(posedge clk)
	begin
		if (rst)
		begin
			shut_cnt <= 0;
			fatal_cnt <= 0;
		end
		else if (os_evt === 1'b1 && os_evt_restart === 1'b1)
			fatal_cnt <= fatal_cnt + 1;
		else if (os_evt === 1'b1)
			shut_cnt <= shut_cnt + 1;
	end
endmodule

// file: tb/testbench.sv
// self-checking bench for the boot and runtime watchdog
`timescale 1ns/1ps
module testbench;
	localparam int TK = 1;  // cycles per ms tick, short for speed
	logic        clk = 0;   // clock
	logic        rst = 1;   // reset
	logic        cyc = 0;   // bus cycle
	logic        stb = 0;   // bus strobe
	logic        we = 0;    // write
	logic [3:0]  sel = 0;   // lanes
	logic [7:0]  adr = 0;   // address
	logic [31:0] dat = 0;   // write data
	logic [31:0] rdat;      // read data
	logic [31:0] q;         // last read
	logic        ack, irq, srst, pwr, ose, osr; // design outputs
	int          fails = 0;     // mismatches
	int          tests_run = 0; // comparisons
	int          a, t, rs, nos; // model state
	int          ev[3], tm[3];  // stage actions and timeout codes
	always #2.5 clk = ~clk;
	mbw_wdt #(.TICK_CYC(TK)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq(irq), .sys_rst_req(srst), .pwr_btn_evt(pwr), .os_evt(ose),
		.os_evt_restart(osr));
	mbw_os_model os_m (.clk(clk), .rst(rst), .os_evt(ose), .os_evt_restart(osr),
		.shut_cnt(), .fatal_cnt());
	// ----
	// bus, compare and wait helpers
	// ----
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			$display("BAD %s exp %h got %h", nm, e, s);
			fails++;
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		@(posedge clk);
		{cyc, stb, we} <= {2'b11, w};
		{adr, dat, sel} <= {ad, d, 4'hF};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		{cyc, stb} <= 2'b00;
		chk("bus ack", 1, n < 20);
		if (n >= 20)
			print_verdict();
	endtask
	// wait for an action pulse: 1 os, 2 reset, 3 power
	task automatic wait_act(input int lim);
		a = 0;
		t = 0;
		while (a == 0 && t < lim)
		begin
			@(posedge clk);
			t++;
			a = (ose === 1'b1) ? 1 : (srst === 1'b1) ? 2 : (pwr === 1'b1) ? 3 : 0;
		end
		chk("action wait", 1, a != 0);
		if (a == 0)
			print_verdict();
	endtask
	function automatic bit near(input int tt, input int ms);
		return tt >= ms * TK - 8 && tt <= ms * TK + 8;
	endfunction
	// ----
	// scenarios
	// ----
	initial
	begin
		void'($urandom(32'hA645));
		nos = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int r = 0; r <= 8'h1C; r += 4)
		begin
			bus(0, r[7:0], 0);
			chk("reset reg", (r == 0) ? 32'h208 : 32'h0, q);
		end
		// single event run with random actions, timeouts and os kind
		for (int k = 0; k < 3; k++)
		begin
			ev[k] = $urandom_range(3, 1);
			tm[k] = $urandom_range(1, 0);
		end
		rs = $urandom_range(1, 0);
		bus(1, 8'h04, {20'h0, tm[2][3:0], tm[1][3:0], tm[0][3:0]});
		bus(1, 8'h00, 32'h28 | ev[0] << 9 | ev[1] << 11 | ev[2] << 13 | rs << 15);
		bus(1, 8'h08, 32'h2);
		for (int k = 0; k < 3; k++)
		begin
			wait_act(5000);
			chk("stage act", ev[k], a);
			chk("stage time", 1, near(t, tm[k] ? 2000 : 1000));
			nos += (ev[k] == 1);
		end
		bus(0, 8'h18, 0);
		chk("single end", 0, q[2:0]);
		chk("os notices", nos, rs ? os_m.fatal_cnt : os_m.shut_cnt);
		// repeated stage 1, restart by trigger, then one-time stop
		bus(1, 8'h04, 0);
		bus(1, 8'h00, 32'h638);
		bus(1, 8'h08, 32'h2);
		for (int k = 0; k < 2; k++)
		begin
			wait_act(2000);
			chk("repeat act", 3, a);
			chk("repeat time", 1, near(t, 1000));
		end
		repeat (500) @(posedge clk);
		bus(1, 8'h08, 32'h1);
		wait_act(2000);
		chk("trigger time", 1, near(t, 1000));
		bus(1, 8'h00, 32'h618);
		bus(1, 8'h08, 32'h1);
		bus(0, 8'h18, 0);
		chk("one-time off", 0, q[2:0]);
		// start delay of 10 s before a reset action
		bus(1, 8'h00, 32'h468);
		bus(1, 8'h08, 32'h2);
		bus(0, 8'h18, 0);
		chk("delay state", 1, q[2:0]);
		wait_act(15000);
		chk("delay act", 2, a);
		chk("delay time", 1, near(t, 11000));
		// boot timer held by a prompt, then expiry with interrupt
		bus(1, 8'h10, 32'hF);
		bus(1, 8'h14, 32'h1);
		bus(1, 8'h00, 32'h9);
		bus(1, 8'h0C, 32'h3);
		repeat (2000) @(posedge clk);
		bus(1, 8'h0C, 32'h1);
		wait_act(40000);
		chk("boot act", 2, a);
		chk("boot time", 1, near(t, 30000));
		bus(0, 8'h0C, 0);
		chk("post flag", 0, q[0]);
		chk("irq set", 1, irq);
		bus(1, 8'h14, 32'h0);
		bus(1, 8'h10, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq clear", 0, irq);
		// stage 1 code none still raises an os event; clearing mode stops
		bus(1, 8'h00, 32'h20);
		bus(1, 8'h08, 32'h2);
		wait_act(2000);
		chk("stage1 none", 1, a);
		bus(1, 8'h08, 32'h2);
		bus(1, 8'h00, 32'h0);
		bus(0, 8'h18, 0);
		chk("mode off", 0, q[2:0]);
		print_verdict();
	end
endmodule
